/* File: scss_params.svh */
// offsets, field positions, widths and reset values of the clock source select block
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

`define SCSS_ADDR_W 4
`define SCSS_DATA_W 16

`define SCSS_OFS_SYS_CFG 4'h0
`define SCSS_OFS_PLL_CFG 4'h1
`define SCSS_OFS_FB_MULT 4'h2
`define SCSS_OFS_OUT_DIV 4'h3
`define SCSS_OFS_PRESCALE 4'h4
`define SCSS_OFS_STATUS 4'h5

`define SCSS_POS_VCO_BYPASS 0
`define SCSS_POS_REF_INTERNAL 1
`define SCSS_POS_BAND_LO 2
`define SCSS_POS_INPUT_DIVIDER_FIELD_LO 4

`define SCSS_SEL_W 2
`define SCSS_BAND_W 2
`define SCSS_INPUT_DIVIDER_FIELD_W 4
`define SCSS_FEEDBACK_MULTIPLIER_FIELD_W 7
`define SCSS_OUTPUT_DIVIDER_FIELD_W 7
`define SCSS_BYPASS_PRESCALER_FIELD_W 10
`define SCSS_CNT_W 11

`define SCSS_SEL_WAKEUP 2'h0
`define SCSS_SEL_PLL 2'h2
`define SCSS_SEL_DIRECT 2'h3

`define SCSS_RST_SEL 2'h0
`define SCSS_RST_BAND 2'h0

`endif

/* File: scss_pkg.sv */
// types of the clock source select block
`include "scss_params.svh"

package scss_pkg;

  typedef enum logic [1:0] {
    SCSS_MODE_WAKEUP = 2'h0,
    SCSS_MODE_PLL = 2'h1,
    SCSS_MODE_PRESCALE = 2'h2,
    SCSS_MODE_DIRECT = 2'h3
  } scss_mode_type;

  typedef enum logic [1:0] {
    SCSS_ST_RUN = 2'b01,
    SCSS_ST_SWITCH = 2'b10
  } scss_state_type;

  typedef struct packed {
    logic wakeup;
    logic ext;
    logic crystal;
    logic internal;
    logic vco;
  } scss_pins_type;

  typedef struct packed {
    logic [`SCSS_SEL_W-1:0] clock_source_select;
    logic vco_bypass;
    logic ref_internal;
    logic [`SCSS_BAND_W-1:0] vco_band_select;
    logic [`SCSS_INPUT_DIVIDER_FIELD_W-1:0] input_divider_field;
    logic [`SCSS_FEEDBACK_MULTIPLIER_FIELD_W-1:0] feedback_multiplier_field;
    logic [`SCSS_OUTPUT_DIVIDER_FIELD_W-1:0] output_divider_field;
    logic [`SCSS_BYPASS_PRESCALER_FIELD_W-1:0] bypass_prescaler_field;
  } scss_cfg_type;

  typedef struct packed {
    scss_pins_type sync1;
    scss_pins_type sync2;
    scss_pins_type sync3;
    scss_cfg_type cfg;
    scss_state_type fsm;
    scss_mode_type active;
    logic [`SCSS_CNT_W-1:0] cnt;
    logic sys_clk;
    logic pll_enable;
    logic [`SCSS_INPUT_DIVIDER_FIELD_W:0] pll_p;
    logic [`SCSS_FEEDBACK_MULTIPLIER_FIELD_W:0] pll_n;
    logic [`SCSS_OUTPUT_DIVIDER_FIELD_W:0] pll_k2;
    logic [`SCSS_DATA_W-1:0] rd_data;
  } scss_regs_type;

endpackage : scss_pkg

/* File: scss_core.sv */
// system clock source selection, dividers and glitch-free switch
// Summary of operation
// - select 10, bypass 0: system clock from PLL
// - each divider factor is field plus one
// - PLL output is input times N over P*K2
// - PLL reference: crystal pin or internal oscillator
// - system clock is VCO divided by K2
// - two-bit VCO band field picks frequency band
// - select 00: wakeup clock, undivided
// - select 11: external clock pin passed through
// - select 10, bypass 1: oscillator over K1
//
// Implementation choices: strobed register access and the register addresses.
`include "scss_params.svh"

module scss_core (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [`SCSS_ADDR_W-1:0] addr,
  input wire logic [`SCSS_DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [`SCSS_DATA_W-1:0] rd_data,
  // clock source pins
  input wire logic wakeup_clk,
  input wire logic external_clock_pin,
  input wire logic crystal_input_pin,
  input wire logic internal_osc_clk,
  input wire logic vco_clk,
  // analog pll control
  output logic pll_enable,
  output logic pll_ref_internal,
  output logic [`SCSS_BAND_W-1:0] vco_band_select,
  output logic [`SCSS_INPUT_DIVIDER_FIELD_W:0] pll_p,
  output logic [`SCSS_FEEDBACK_MULTIPLIER_FIELD_W:0] pll_n,
  output logic [`SCSS_OUTPUT_DIVIDER_FIELD_W:0] pll_k2,
  // system clock
  output logic sys_clk
);

  scss_pkg::scss_regs_type state_r;
  scss_pkg::scss_regs_type state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic src_level(input scss_pkg::scss_mode_type m,
                                     input scss_pkg::scss_pins_type v,
                                     input logic ref_int);
    case (m)
      scss_pkg::SCSS_MODE_WAKEUP: src_level = v.wakeup;
      scss_pkg::SCSS_MODE_DIRECT: src_level = v.ext;
      scss_pkg::SCSS_MODE_PLL: src_level = v.vco;
      scss_pkg::SCSS_MODE_PRESCALE: src_level = ref_int ? v.internal : v.crystal;
      default: src_level = 1'b0;
    endcase
  endfunction : src_level

  function automatic logic [`SCSS_CNT_W-1:0] div_of(input scss_pkg::scss_mode_type m,
                                                    input scss_pkg::scss_cfg_type c);
    case (m)
      scss_pkg::SCSS_MODE_PLL: div_of = {4'h0, c.output_divider_field} + 11'h001;
      scss_pkg::SCSS_MODE_PRESCALE: div_of = {1'b0, c.bypass_prescaler_field} + 11'h001;
      default: div_of = 11'h001;
    endcase
  endfunction : div_of

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    scss_pkg::scss_mode_type target;
    logic lvl;
    logic prev;
    logic [`SCSS_CNT_W-1:0] k;
    logic [`SCSS_CNT_W-1:0] half;
    logic gen_out;
    target = state_r.active;
    lvl = 1'b0;
    prev = 1'b0;
    k = 11'h001;
    half = 11'h000;
    gen_out = 1'b0;
    state_nxt = state_r;
    state_nxt.sync1 = {wakeup_clk, external_clock_pin, crystal_input_pin, internal_osc_clk,
                       vco_clk};
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sync3 = state_r.sync2;

    // register writes
    if (wr_stb) begin
      case (addr)
        `SCSS_OFS_SYS_CFG: begin
          state_nxt.cfg.clock_source_select = wr_data[`SCSS_SEL_W-1:0];
        end
        `SCSS_OFS_PLL_CFG: begin
          state_nxt.cfg.vco_bypass = wr_data[`SCSS_POS_VCO_BYPASS];
          state_nxt.cfg.ref_internal = wr_data[`SCSS_POS_REF_INTERNAL];
          state_nxt.cfg.vco_band_select =
            wr_data[`SCSS_POS_BAND_LO +: `SCSS_BAND_W];
          state_nxt.cfg.input_divider_field = wr_data[`SCSS_POS_INPUT_DIVIDER_FIELD_LO +: `SCSS_INPUT_DIVIDER_FIELD_W];
        end
        `SCSS_OFS_FB_MULT: begin
          state_nxt.cfg.feedback_multiplier_field = wr_data[`SCSS_FEEDBACK_MULTIPLIER_FIELD_W-1:0];
        end
        `SCSS_OFS_OUT_DIV: begin
          state_nxt.cfg.output_divider_field = wr_data[`SCSS_OUTPUT_DIVIDER_FIELD_W-1:0];
        end
        `SCSS_OFS_PRESCALE: begin
          state_nxt.cfg.bypass_prescaler_field = wr_data[`SCSS_BYPASS_PRESCALER_FIELD_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle only
    state_nxt.rd_data = 16'h0000;
    if (rd_stb) begin
      case (addr)
        `SCSS_OFS_SYS_CFG: state_nxt.rd_data = {14'h0000, state_r.cfg.clock_source_select};
        `SCSS_OFS_PLL_CFG: state_nxt.rd_data = {8'h00, state_r.cfg.input_divider_field,
                                                state_r.cfg.vco_band_select,
                                                state_r.cfg.ref_internal,
                                                state_r.cfg.vco_bypass};
        `SCSS_OFS_FB_MULT: state_nxt.rd_data = {9'h000, state_r.cfg.feedback_multiplier_field};
        `SCSS_OFS_OUT_DIV: state_nxt.rd_data = {9'h000, state_r.cfg.output_divider_field};
        `SCSS_OFS_PRESCALE: state_nxt.rd_data = {6'h00, state_r.cfg.bypass_prescaler_field};
        `SCSS_OFS_STATUS: state_nxt.rd_data = {12'h000, state_r.sys_clk,
                                               state_r.fsm == scss_pkg::SCSS_ST_SWITCH,
                                               state_r.active};
        default: state_nxt.rd_data = 16'h0000;
      endcase
    end

    // requested mode; the reserved code keeps the running source
    case (state_r.cfg.clock_source_select)
      `SCSS_SEL_WAKEUP: target = scss_pkg::SCSS_MODE_WAKEUP;
      `SCSS_SEL_DIRECT: target = scss_pkg::SCSS_MODE_DIRECT;
      `SCSS_SEL_PLL: target = state_r.cfg.vco_bypass ? scss_pkg::SCSS_MODE_PRESCALE
                                                     : scss_pkg::SCSS_MODE_PLL;
      default: target = state_r.active;
    endcase

    // analog pll factors, each field plus one
    state_nxt.pll_enable = (target == scss_pkg::SCSS_MODE_PLL) ||
                           (state_r.active == scss_pkg::SCSS_MODE_PLL);
    state_nxt.pll_p = {1'b0, state_r.cfg.input_divider_field} + 5'h01;
    state_nxt.pll_n = {1'b0, state_r.cfg.feedback_multiplier_field} + 8'h01;
    state_nxt.pll_k2 = {1'b0, state_r.cfg.output_divider_field} + 8'h01;

    // divider on the active source, one period per k source cycles
    lvl = src_level(state_r.active, state_r.sync2, state_r.cfg.ref_internal);
    prev = src_level(state_r.active, state_r.sync3, state_r.cfg.ref_internal);
    k = div_of(state_r.active, state_r.cfg);
    half = (k >> 1) + {10'h000, k[0]};
    if (lvl && !prev) begin
      state_nxt.cnt = (state_r.cnt >= k - 11'h001) ? 11'h000 : state_r.cnt + 11'h001;
    end
    gen_out = (k == 11'h001) ? lvl : (state_nxt.cnt < half);

    // switching: hold output low, hand over while both clocks are low
    case (state_r.fsm)
      scss_pkg::SCSS_ST_RUN: begin
        state_nxt.sys_clk = gen_out;
        if (target != state_r.active) begin
          state_nxt.fsm = scss_pkg::SCSS_ST_SWITCH;
        end
      end
      scss_pkg::SCSS_ST_SWITCH: begin
        state_nxt.sys_clk = state_r.sys_clk & gen_out;
        if (target == state_r.active) begin
          state_nxt.fsm = scss_pkg::SCSS_ST_RUN;
        end else if (!state_r.sys_clk &&
                     !src_level(target, state_r.sync2, state_r.cfg.ref_internal)) begin
          state_nxt.active = target;
          state_nxt.cnt = div_of(target, state_r.cfg) - 11'h001;
          state_nxt.sys_clk = 1'b0;
          state_nxt.fsm = scss_pkg::SCSS_ST_RUN;
        end
      end
      default: begin
        state_nxt.fsm = scss_pkg::SCSS_ST_RUN;
        state_nxt.sys_clk = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
      state_r.cfg.clock_source_select <= `SCSS_RST_SEL;
      state_r.cfg.vco_band_select <= `SCSS_RST_BAND;
      state_r.fsm <= scss_pkg::SCSS_ST_RUN;
      state_r.active <= scss_pkg::SCSS_MODE_WAKEUP;
      state_r.pll_p <= 5'h01;
      state_r.pll_n <= 8'h01;
      state_r.pll_k2 <= 8'h01;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data = state_r.rd_data;
  assign sys_clk = state_r.sys_clk;
  assign pll_enable = state_r.pll_enable;
  assign pll_ref_internal = state_r.cfg.ref_internal;
  assign vco_band_select = state_r.cfg.vco_band_select;
  assign pll_p = state_r.pll_p;
  assign pll_n = state_r.pll_n;
  assign pll_k2 = state_r.pll_k2;

endmodule : scss_core

/* File: scss_core_sva.sv */
// assertions on the clock source select ports
`include "scss_params.svh"
module scss_core_sva (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // register port
  input wire logic [`SCSS_ADDR_W-1:0] addr,
  input wire logic [`SCSS_DATA_W-1:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [`SCSS_DATA_W-1:0] rd_data,
  // pll control
  input wire logic pll_ref_internal,
  input wire logic [`SCSS_BAND_W-1:0] vco_band_select,
  input wire logic [`SCSS_INPUT_DIVIDER_FIELD_W:0] pll_p,
  input wire logic [`SCSS_FEEDBACK_MULTIPLIER_FIELD_W:0] pll_n,
  input wire logic [`SCSS_OUTPUT_DIVIDER_FIELD_W:0] pll_k2,
  // system clock
  input wire logic sys_clk
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not zero outside read");
  a_rd_unmapped: assert property (rd_stb && addr > 4'h5 |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_status_upper: assert property (rd_stb && addr == 4'h5 |=> rd_data[15:4] == 12'h000)
    else $error("status upper bits set");
  a_p_factor: assert property (wr_stb && addr == 4'h1 |-> ##2
    pll_p == {1'b0, $past(wr_data[7:4], 2)} + 5'h01)
    else $error("input divider not field plus one");
  a_n_factor: assert property (wr_stb && addr == 4'h2 |-> ##2
    pll_n == {1'b0, $past(wr_data[6:0], 2)} + 8'h01)
    else $error("multiplier not field plus one");
  a_k2_factor: assert property (wr_stb && addr == 4'h3 |-> ##2
    pll_k2 == {1'b0, $past(wr_data[6:0], 2)} + 8'h01)
    else $error("output divider not field plus one");
  a_band_write: assert property (wr_stb && addr == 4'h1 |=>
    vco_band_select == $past(wr_data[3:2]))
    else $error("band field not applied");
  a_ref_write: assert property (wr_stb && addr == 4'h1 |=>
    pll_ref_internal == $past(wr_data[1]))
    else $error("reference select not applied");
  // no system clock phase shorter than two cycles, across a switch too
  a_clk_high_min: assert property ($rose(sys_clk) |=> sys_clk)
    else $error("system clock high phase truncated");
  a_clk_low_min: assert property ($fell(sys_clk) |=> !sys_clk)
    else $error("system clock low phase truncated");
endmodule : scss_core_sva
bind scss_core scss_core_sva scss_core_sva_inst (.clock(clock), .arst_n(arst_n), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .pll_ref_internal(pll_ref_internal), .vco_band_select(vco_band_select),
  .pll_p(pll_p), .pll_n(pll_n), .pll_k2(pll_k2), .sys_clk(sys_clk));

/* File: tb.sv */
// self-checking bench of the clock source select block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, arst_n = 0, wr_stb = 0, rd_stb = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wr_data = 16'h0000, rd_data, v;
  logic wk = 0, ext = 0, xtal = 0, osc = 0, vco = 0;
  logic pll_enable, pll_ref_internal, sys_clk;
  logic [1:0] vco_band_select;
  logic [4:0] pll_p;
  logic [7:0] pll_n, pll_k2;
  int n_fail = 0, tests_run = 0;
  scss_core scss_core_inst (.clock(clock), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .wakeup_clk(wk),
    .external_clock_pin(ext), .crystal_input_pin(xtal), .internal_osc_clk(osc),
    .vco_clk(vco), .pll_enable(pll_enable), .pll_ref_internal(pll_ref_internal),
    .vco_band_select(vco_band_select), .pll_p(pll_p), .pll_n(pll_n), .pll_k2(pll_k2),
    .sys_clk(sys_clk));
  initial begin
    forever #12.5 clock = ~clock;
  end
  // source clocks, phases unrelated to clock
  initial begin
    #3 forever #250 wk = ~wk;
  end
  initial begin
    #7 forever #200 ext = ~ext;
  end
  initial begin
    #5 forever #100 xtal = ~xtal;
  end
  initial begin
    #9 forever #200 osc = ~osc;
  end
  initial begin
    #2 forever #100 vco = ~vco;
  end
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask : rd
  // switch source, then count system clock rising edges in 2048 cycles
  task run_mode(input logic [3:0] a, input logic [15:0] d, input logic [1:0] m,
                input logic pen, input int exp);
    int cnt;
    logic prev;
    cnt = 0;
    prev = 1'b0;
    wr(a, d);
    repeat (300) @(posedge clock);
    rd(4'h5, v);
    chk({13'h0, v[2:0]}, {14'h0, m});
    chk({15'h0, pll_enable}, {15'h0, pen});
    repeat (2048) begin
      @(negedge clock);
      if (sys_clk && !prev) cnt++;
      prev = sys_clk;
    end
    chk({15'h0, (cnt >= exp - 1) && (cnt <= exp + 1)}, 16'h0001);
    $display("mode test done, %0d edges", cnt);
  endtask : run_mode
  initial begin
    #1000000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk({3'h0, pll_p, pll_k2}, 16'h0101);
    chk({8'h0, pll_n}, 16'h0001);
    wr(4'h1, 16'h0034);
    wr(4'h2, 16'h007f);
    wr(4'h3, 16'h0003);
    wr(4'h4, 16'h0007);
    wr(4'hf, 16'hffff);
    repeat (3) @(negedge clock);
    chk({3'h0, pll_p, pll_n}, 16'h0480);
    chk({6'h0, vco_band_select, pll_k2}, 16'h0104);
    rd(4'h1, v);
    chk(v, 16'h0034);
    rd(4'h2, v);
    chk(v, 16'h007f);
    rd(4'hf, v);
    chk(v, 16'h0000);
    $display("register test done");
    run_mode(4'h0, 16'h0000, 2'h0, 1'b0, 102);
    run_mode(4'h0, 16'h0003, 2'h3, 1'b0, 128);
    run_mode(4'h0, 16'h0001, 2'h3, 1'b0, 128);
    run_mode(4'h0, 16'h0002, 2'h1, 1'b1, 64);
    run_mode(4'h1, 16'h0035, 2'h2, 1'b0, 32);
    run_mode(4'h1, 16'h0037, 2'h2, 1'b0, 16);
    chk({15'h0, pll_ref_internal}, 16'h0001);
    run_mode(4'h0, 16'h0000, 2'h0, 1'b0, 102);
    stop_test();
  end
endmodule : tb
